// ---- rtl/rsmb_pkg.sv ----
// Purpose: Shared constants and types for the RS-485 slave serial port
// Assumes: 40 MHz reference clock; times kept in ms, cycles derived in the port
// Notes:   Settings arrive on a plain write port, not a bus
package rsmb_pkg;

  localparam int unsigned CLK_HZ_DEF = 40_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned T_INIT_MS  = 1;
  localparam int unsigned T_LEAD_MS  = 1;
  localparam int unsigned T_HOLD_MS  = 1;
  localparam int unsigned T_RESP_MS  = 100;

  localparam int unsigned BUF_BYTES = 128;
  localparam int unsigned BUF_AW    = 7;
  localparam logic [7:0]  BUF_MAX   = 8'h80;
  localparam logic [15:0] MAX_REGS  = 16'h0010;

  localparam logic [7:0] RATE_RST      = 8'h06;
  localparam logic [7:0] RATE_MAX      = 8'h09;
  localparam logic [7:0] RATE_ASCII_PROTOCOL_CODE_MAX = 8'h07;
  localparam logic [7:0] TURN_RST      = 8'h02;
  localparam logic [7:0] TURN_MAX      = 8'hfa;
  localparam logic [7:0] TURN_EXT_MIN  = 8'h02;
  localparam logic [7:0] ADDR_RST      = 8'h01;
  localparam logic [7:0] ADDR_MAX      = 8'hf7;
  localparam logic [7:0] ADDR_BCAST    = 8'h00;
  localparam logic [7:0] DERIV_MAX     = 8'h10;

  localparam logic [1:0] ascii_protocol_code  = 2'h0;
  localparam logic [1:0] binary_protocol_code = 2'h1;
  localparam logic [1:0] keypad_protocol_code = 2'h2;
  localparam logic [1:0] PROTO_RST            = binary_protocol_code;

  // Start + payload + stop bits per character, plus a parity bit in ascii
  localparam logic [3:0] CHAR_BITS_ASCII = 4'ha;
  localparam logic [3:0] CHAR_BITS_BIN   = 4'hb;
  localparam logic [3:0] PAYLOAD_LAST    = 4'h8;
  localparam logic [3:0] SIL_HALF_CHARS  = 4'h7;

  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_IN    = 8'h04;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;

  localparam logic [1:0] SEL_RATE  = 2'h0;
  localparam logic [1:0] SEL_TURN  = 2'h1;
  localparam logic [1:0] SEL_PROTO = 2'h2;
  localparam logic [1:0] SEL_ADDR  = 2'h3;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RX   = 6'h02,
    S_WAIT = 6'h04,
    S_LEAD = 6'h08,
    S_TX   = 6'h10,
    S_HOLD = 6'h20
  } rsmb_state_e;

  typedef struct packed {
    logic       wr;
    logic       via_link;
    logic [1:0] sel;
    logic [7:0] data;
  } rsmb_cfg_wr_s;

  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] turn;
    logic [7:0] addr;
    logic [1:0] proto;
  } rsmb_cfg_s;

  typedef struct packed {
    logic       ok;
    logic       exc;
    logic       err;
    logic       bcast;
    logic [7:0] len;
  } rsmb_frame_s;

  typedef struct packed {
    rsmb_state_e st;
    rsmb_cfg_s   cfg;
    logic [7:0]  rate_new;
    logic [1:0]  proto_new;
    logic        rate_pend;
    logic        proto_pend;
    logic [7:0]  deriv;
    logic        deriv_done;
    logic [15:0] rev;
    logic        rxd_q;
    logic        rx_busy;
    logic [3:0]  rx_bit;
    logic [17:0] rx_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_len;
    logic        rx_ovf;
    logic        rx_bad;
    logic [7:0]  hdr_addr;
    logic [7:0]  hdr_fc;
    logic [15:0] hdr_qty;
    logic [24:0] sil;
    logic [24:0] tmr;
    logic [24:0] rcnt;
    logic        go;
    logic [7:0]  tx_len;
    logic [7:0]  tx_idx;
    logic [3:0]  tx_bit;
    logic [17:0] tx_cnt;
    logic [10:0] tx_sh;
    logic        de;
    rsmb_frame_s frm;
    logic        cfg_err;
    logic        timeout;
  } rsmb_st_s;

  function automatic int unsigned baud_of(input logic [7:0] code);
    case (code)
      8'h00:   baud_of = 300;
      8'h01:   baud_of = 600;
      8'h02:   baud_of = 1200;
      8'h03:   baud_of = 2400;
      8'h04:   baud_of = 4800;
      8'h05:   baud_of = 9600;
      8'h07:   baud_of = 38400;
      8'h08:   baud_of = 57600;
      8'h09:   baud_of = 115200;
      default: baud_of = 19200;
    endcase
  endfunction : baud_of

endpackage : rsmb_pkg

// ---- rtl/rsmb_port.sv ----
// Purpose: Half-duplex RS-485 slave port: framing, turnaround, silence
// Assumes: rxd synchronous to ref_clk; firmware builds replies in the buffer
// Notes:   One 128-byte buffer serves both the request and the reply
// Functional notes
// - Reply start bounded to 100 ms after request
// - At most 16 registers per transaction
// - Message buffer limited to 128 bytes
// - Rate codes 0-9, default 6, 8-9 binary
// - Rate change over link applies after reply
// - Reply waits at least 1 ms
// - Turnaround 0: driver and data together
// - Turnaround 1: driver, then data 1 ms later
// - Turnaround 2+: extra delay, then 1 ms lead
// - Turnaround 0-250 ms, default 2
// - Driver held up to 1 ms after last character
// - Frame ends on silence: max(3.5 chars, turnaround)
// - 32-bit values travel as register pairs
// - Keypad-only protocol blocks host access
// - Read-only derivative code 0-16 from power-up
// - Protocol codes 0 ascii, 1 binary, 2 keypad
// - Framing 7E1 ascii, 8N2 binary
// - Always slave, address 1-247, 0 broadcast
`timescale 1ns/1ps
module rsmb_port
  import rsmb_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF,
  parameter logic [15:0] FW_REV = 16'h0100  // Arbitrary value
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   tx_en,
  input  wire rsmb_cfg_wr_s      cfg_wr,
  output rsmb_cfg_s              cfg,
  output logic                   cfg_err,
  input  wire logic [7:0]        derivative_strap,
  output logic [7:0]             derivative_code,
  output logic [15:0]            firmware_revision,
  input  wire logic              buf_wr,
  input  wire logic [BUF_AW-1:0] buf_addr,
  input  wire logic [7:0]        buf_wdata,
  output logic [7:0]             buf_rdata,
  input  wire logic              tx_start,
  input  wire logic [7:0]        tx_len,
  output rsmb_frame_s            frame,
  output logic                   resp_timeout
);

  localparam int unsigned MS_CYC   = CLK_HZ / MS_PER_S;
  localparam logic [24:0] MS25     = 25'(MS_CYC);
  localparam logic [24:0] INIT_CYC = 25'(T_INIT_MS * MS_CYC);
  localparam logic [24:0] LEAD_CYC = 25'(T_LEAD_MS * MS_CYC);
  localparam logic [24:0] HOLD_CYC = 25'(T_HOLD_MS * MS_CYC);
  localparam logic [24:0] RESP_CYC = 25'(T_RESP_MS * MS_CYC);

  function automatic logic [17:0] bit_cyc(input logic [7:0] code);
    bit_cyc = 18'(CLK_HZ / baud_of(code));
  endfunction : bit_cyc

  function automatic logic [3:0] char_bits(input logic [1:0] p);
    char_bits = (p == ascii_protocol_code) ? CHAR_BITS_ASCII : CHAR_BITS_BIN;
  endfunction : char_bits

  // Line bits LSB first, padded with idle ones
  function automatic logic [10:0] frame_of(input logic [7:0] b, input logic [1:0] p);
    frame_of = (p == ascii_protocol_code) ? {2'b11, ^b[6:0], b[6:0], 1'b0}
                                          : {2'b11, b, 1'b0};
  endfunction : frame_of

  function automatic logic [24:0] sil_cyc(input logic [17:0] b, input logic [3:0] c,
                                          input logic [7:0] t);
    logic [24:0] ch;
    logic [24:0] tm;
    ch = (25'(b) * 25'(c) * 25'(SIL_HALF_CHARS)) >> 1;
    tm = 25'(t) * MS25;
    sil_cyc = (ch > tm) ? ch : tm;
  endfunction : sil_cyc

  rsmb_st_s          st_q;
  rsmb_st_s          st_d;
  logic [7:0]        mem [BUF_BYTES];
  logic              we;
  logic [BUF_AW-1:0] wa;
  logic [7:0]        wd;
  logic [7:0]        rdata_q;
  logic [17:0]       bitc;
  logic [3:0]        cbits;
  logic [24:0]       silc;
  logic [24:0]       gap;
  logic              defer;
  logic              bin;
  logic              qty_bad;
  logic [7:0]        rx_byte;
  logic [7:0]        tx_first;
  logic [7:0]        tx_next;

  assign bitc     = bit_cyc(st_q.cfg.rate);
  assign cbits    = char_bits(st_q.cfg.proto);
  assign silc     = sil_cyc(bitc, cbits, st_q.cfg.turn);
  assign gap      = INIT_CYC + ((st_q.cfg.turn >= TURN_EXT_MIN) ?
                    25'(st_q.cfg.turn) * MS25 : 25'h0);
  assign defer    = cfg_wr.via_link || st_q.st != S_IDLE;
  assign bin      = st_q.cfg.proto != ascii_protocol_code;
  // Counts 16-bit registers, so a 32-bit value costs two
  assign qty_bad  = bin && (st_q.hdr_fc == FC_RD_HOLD || st_q.hdr_fc == FC_RD_IN ||
                    st_q.hdr_fc == FC_WR_MULTI) &&
                    (st_q.hdr_qty > MAX_REGS || st_q.hdr_qty == 16'h0000);
  assign rx_byte  = bin ? st_q.rx_sh : {1'b0, st_q.rx_sh[6:0]};
  assign tx_first = mem[0];
  assign tx_next  = mem[st_q.tx_idx[BUF_AW-1:0] + 7'h01];

  always_comb begin
    st_d         = st_q;
    we           = 1'b0;
    wa           = buf_addr;
    wd           = buf_wdata;
    st_d.frm     = '0;
    st_d.cfg_err = 1'b0;
    st_d.timeout = 1'b0;
    st_d.rxd_q   = rxd;
    if (!st_q.deriv_done) begin
      st_d.deriv_done = 1'b1;
      st_d.deriv      = (derivative_strap > DERIV_MAX) ? DERIV_MAX : derivative_strap;
    end
    if (st_q.st == S_IDLE) begin
      if (st_q.rate_pend) begin
        st_d.cfg.rate  = st_q.rate_new;
        st_d.rate_pend = 1'b0;
      end
      if (st_q.proto_pend) begin
        st_d.cfg.proto  = st_q.proto_new;
        st_d.proto_pend = 1'b0;
      end
    end
    if (cfg_wr.wr) begin
      case (cfg_wr.sel)
        SEL_RATE: begin
          if (cfg_wr.data > RATE_MAX || (!bin && cfg_wr.data > RATE_ASCII_PROTOCOL_CODE_MAX)) begin
            st_d.cfg_err = 1'b1;
          end else if (defer) begin
            st_d.rate_new  = cfg_wr.data;
            st_d.rate_pend = 1'b1;
          end else begin
            st_d.cfg.rate = cfg_wr.data;
          end
        end
        SEL_TURN: begin
          if (cfg_wr.data > TURN_MAX) st_d.cfg_err = 1'b1;
          else st_d.cfg.turn = cfg_wr.data;
        end
        SEL_PROTO: begin
          if (cfg_wr.data > {6'h00, keypad_protocol_code}) begin
            st_d.cfg_err = 1'b1;
          end else if (defer) begin
            st_d.proto_new  = cfg_wr.data[1:0];
            st_d.proto_pend = 1'b1;
          end else begin
            st_d.cfg.proto = cfg_wr.data[1:0];
          end
        end
        default: begin
          if (cfg_wr.data == ADDR_BCAST || cfg_wr.data > ADDR_MAX) st_d.cfg_err = 1'b1;
          else st_d.cfg.addr = cfg_wr.data;
        end
      endcase
    end
    // Firmware owns the buffer except while a frame moves on the line
    if (buf_wr && st_q.st != S_RX && st_q.st != S_TX) we = 1'b1;
    case (st_q.st)
      S_IDLE: begin
        if (st_q.rxd_q && !rxd) begin
          st_d.st      = S_RX;
          st_d.rx_busy = 1'b1;
          st_d.rx_bit  = 4'h0;
          st_d.rx_cnt  = bitc >> 1;
          st_d.rx_len  = 8'h00;
          st_d.rx_ovf  = 1'b0;
          st_d.rx_bad  = 1'b0;
          st_d.sil     = 25'h0;
        end
      end
      S_RX: begin
        if (st_q.rx_busy) begin
          st_d.sil = 25'h0;
          if (st_q.rx_cnt != 18'h0) begin
            st_d.rx_cnt = st_q.rx_cnt - 18'h1;
          end else begin
            st_d.rx_cnt = bitc - 18'h1;
            st_d.rx_bit = st_q.rx_bit + 4'h1;
            if (st_q.rx_bit == 4'h0) begin
              if (rxd) st_d.rx_busy = 1'b0;  // Glitch, not a start bit
            end else if (st_q.rx_bit <= PAYLOAD_LAST) begin
              st_d.rx_sh = {rxd, st_q.rx_sh[7:1]};
            end else begin
              if (!rxd || (!bin && ^st_q.rx_sh)) st_d.rx_bad = 1'b1;
              if (st_q.rx_bit == cbits - 4'h1) begin
                st_d.rx_busy = 1'b0;
                if (st_q.rx_len < BUF_MAX) begin
                  we          = 1'b1;
                  wa          = st_q.rx_len[BUF_AW-1:0];
                  wd          = rx_byte;
                  st_d.rx_len = st_q.rx_len + 8'h01;
                  case (st_q.rx_len)
                    8'h00:   st_d.hdr_addr       = rx_byte;
                    8'h01:   st_d.hdr_fc         = rx_byte;
                    8'h04:   st_d.hdr_qty[15:8]  = rx_byte;
                    8'h05:   st_d.hdr_qty[7:0]   = rx_byte;
                    default: st_d.hdr_qty        = st_q.hdr_qty;
                  endcase
                end else begin
                  st_d.rx_ovf = 1'b1;
                end
              end
            end
          end
        end else if (st_q.rxd_q && !rxd) begin
          st_d.rx_busy = 1'b1;
          st_d.rx_bit  = 4'h0;
          st_d.rx_cnt  = bitc >> 1;
        end else if (st_q.sil < silc - 25'h1) begin
          st_d.sil = st_q.sil + 25'h1;
        end else begin
          st_d.st       = S_IDLE;
          st_d.frm.len  = st_q.rx_len;
          st_d.frm.bcast = bin && st_q.hdr_addr == ADDR_BCAST;
          if (st_q.rx_ovf || st_q.rx_bad) begin
            st_d.frm.err = 1'b1;
          end else if (st_q.rx_len == 8'h00 ||
                       st_q.cfg.proto == keypad_protocol_code) begin
            st_d.frm.len = 8'h00;
          end else if (bin && st_q.hdr_addr != st_q.cfg.addr &&
                       st_q.hdr_addr != ADDR_BCAST) begin
            st_d.frm.len = 8'h00;
          end else begin
            st_d.frm.exc = qty_bad;
            st_d.frm.ok  = !qty_bad;
            if (!(bin && st_q.hdr_addr == ADDR_BCAST)) begin
              st_d.st   = S_WAIT;
              st_d.tmr  = 25'h0;
              st_d.rcnt = 25'h0;
              st_d.go   = 1'b0;
            end
          end
        end
      end
      S_WAIT: begin
        st_d.tmr  = st_q.tmr + 25'h1;
        st_d.rcnt = st_q.rcnt + 25'h1;
        if (tx_start && !st_q.go && tx_len != 8'h00 && tx_len <= BUF_MAX) begin
          st_d.go     = 1'b1;
          st_d.tx_len = tx_len;
        end
        if (st_q.go && st_q.tmr >= gap) begin
          st_d.de  = 1'b1;
          st_d.tmr = 25'h0;
          if (st_q.cfg.turn == 8'h00) begin
            st_d.st     = S_TX;
            st_d.tx_idx = 8'h00;
            st_d.tx_bit = 4'h0;
            st_d.tx_cnt = bitc - 18'h1;
            st_d.tx_sh  = frame_of(tx_first, st_q.cfg.proto);
          end else begin
            st_d.st = S_LEAD;
          end
        end else if (!st_q.go && st_q.rcnt >= RESP_CYC - 25'h1) begin
          st_d.timeout = 1'b1;
          st_d.st      = S_IDLE;
        end
      end
      S_LEAD: begin
        st_d.tmr = st_q.tmr + 25'h1;
        if (st_q.tmr == LEAD_CYC - 25'h1) begin
          st_d.st     = S_TX;
          st_d.tx_idx = 8'h00;
          st_d.tx_bit = 4'h0;
          st_d.tx_cnt = bitc - 18'h1;
          st_d.tx_sh  = frame_of(tx_first, st_q.cfg.proto);
        end
      end
      S_TX: begin
        if (st_q.tx_cnt != 18'h0) begin
          st_d.tx_cnt = st_q.tx_cnt - 18'h1;
        end else begin
          st_d.tx_cnt = bitc - 18'h1;
          if (st_q.tx_bit != cbits - 4'h1) begin
            st_d.tx_bit = st_q.tx_bit + 4'h1;
            st_d.tx_sh  = {1'b1, st_q.tx_sh[10:1]};
          end else if (st_q.tx_idx + 8'h01 < st_q.tx_len) begin
            st_d.tx_idx = st_q.tx_idx + 8'h01;
            st_d.tx_bit = 4'h0;
            st_d.tx_sh  = frame_of(tx_next, st_q.cfg.proto);
          end else begin
            st_d.st  = S_HOLD;
            st_d.tmr = 25'h0;
          end
        end
      end
      S_HOLD: begin
        st_d.tmr = st_q.tmr + 25'h1;
        if (st_q.tmr == HOLD_CYC - 25'h1) begin
          st_d.de = 1'b0;
          st_d.st = S_IDLE;
        end
      end
      default: st_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q       <= '0;
      st_q.st    <= S_IDLE;
      st_q.cfg   <= '{rate: RATE_RST, turn: TURN_RST, addr: ADDR_RST, proto: PROTO_RST};
      st_q.rev   <= FW_REV;
      st_q.rxd_q <= 1'b1;
      st_q.tx_sh <= 11'h7ff;
    end else begin
      st_q <= st_d;
    end
  end

  // Buffer has no reset; only the read port register does
  always_ff @(posedge ref_clk) begin
    if (we) mem[wa] <= wd;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) rdata_q <= 8'h00;
    else rdata_q <= mem[buf_addr];
  end

  assign txd               = st_q.tx_sh[0];
  assign tx_en             = st_q.de;
  assign cfg               = st_q.cfg;
  assign cfg_err           = st_q.cfg_err;
  assign derivative_code   = st_q.deriv;
  assign firmware_revision = st_q.rev;
  assign buf_rdata         = rdata_q;
  assign frame             = st_q.frm;
  assign resp_timeout      = st_q.timeout;

  default clocking dclk @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_wait_exit;
    st_q.st == S_WAIT ##1 st_q.st != S_WAIT && st_q.st != S_IDLE;
  endsequence

  property p_gap;
    s_wait_exit |-> $past(st_q.tmr) >= $past(gap);
  endproperty
  a_gap: assert property (p_gap) else $error("reply started before gap");

  property p_turn0;
    (st_q.cfg.turn == 8'h00 ##0 s_wait_exit) |-> st_q.st == S_TX && !txd && tx_en;
  endproperty
  a_turn0: assert property (p_turn0) else $error("turnaround 0 not immediate");

  property p_lead;
    $fell(st_q.st == S_LEAD) |-> st_q.st == S_TX && $past(st_q.tmr) == LEAD_CYC - 25'h1;
  endproperty
  a_lead: assert property (p_lead) else $error("lead time wrong");

  property p_lead_idle;
    st_q.st == S_LEAD |-> tx_en && txd;
  endproperty
  a_lead_idle: assert property (p_lead_idle) else $error("data during lead");

  property p_hold;
    $fell(tx_en) |-> $past(st_q.st) == S_HOLD && $past(st_q.tmr) == HOLD_CYC - 25'h1;
  endproperty
  a_hold: assert property (p_hold) else $error("driver release wrong");

  property p_resp;
    st_q.st == S_WAIT && !st_q.go |-> st_q.rcnt < RESP_CYC;
  endproperty
  a_resp: assert property (p_resp) else $error("response wait overrun");

  property p_buf;
    st_q.rx_len <= BUF_MAX;
  endproperty
  a_buf: assert property (p_buf) else $error("buffer overrun");

  property p_rate_hold;
    st_q.st != S_IDLE ##1 st_q.st != S_IDLE |-> $stable(st_q.cfg.rate);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate changed mid exchange");

  property p_range;
    st_q.cfg.rate <= RATE_MAX && st_q.cfg.turn <= TURN_MAX;
  endproperty
  a_range: assert property (p_range) else $error("setting out of range");

  property p_keypad;
    $past(st_q.cfg.proto) == keypad_protocol_code |-> !frame.ok && !frame.exc;
  endproperty
  a_keypad: assert property (p_keypad) else $error("frame accepted in keypad mode");

  property p_silence;
    frame.ok |-> $past(st_q.sil) == $past(silc) - 25'h1;
  endproperty
  a_silence: assert property (p_silence) else $error("frame ended early");

endmodule : rsmb_port

// ---- testbench/rsmb_host.sv ----
// Purpose: Host master on the half-duplex line: 8N2 sender and receiver
// Assumes: Bench sets the bit time in clock cycles
// Notes:   Line idles high when released, as a biased pair does
`timescale 1ns/1ps
module rsmb_host #(
  parameter int CK = 200_000
) (
  input  wire logic ref_clk,
  input  wire logic txd,
  input  wire logic tx_en,
  output logic      rxd
);
  int         bitc     = 10;
  int         cyc      = 0;
  int         st0, stl;
  logic       stop_bad = 1'b0;
  logic [7:0] txq[$], got[$], b;
  initial rxd = 1'b1;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Start, 8 data LSB first, 2 stop
  task automatic send_q();
    foreach (txq[k]) begin
      rxd <= 1'b0;
      repeat (bitc) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        rxd <= txq[k][i];
        repeat (bitc) @(posedge ref_clk);
      end
      rxd <= 1'b1;
      repeat (2 * bitc) @(posedge ref_clk);
    end
  endtask : send_q
  // Stay quiet while the slave holds the line, longer after a rate change
  task automatic gap(input int ms);
    while (tx_en !== 1'b0) @(posedge ref_clk);
    repeat (ms * CK / 1000) @(posedge ref_clk);
  endtask : gap
  always begin
    do @(posedge ref_clk); while (!(tx_en === 1'b1 && txd === 1'b0));
    if (got.size() == 0)
      st0 = cyc;
    stl = cyc;
    repeat (bitc / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitc) @(posedge ref_clk);
      b[i] = txd;
    end
    got.push_back(b);
    repeat (bitc) @(posedge ref_clk);
    stop_bad |= !txd;
    repeat (bitc) @(posedge ref_clk);
    stop_bad |= !txd;
  end
endmodule : rsmb_host

// ---- testbench/rsmb_port_bench.sv ----
// Purpose: Self-checking bench for the RS-485 slave port
// Assumes: Clock count scaled so 1 ms is 200 cycles
// Notes:   Host model drives the line; bench plays the firmware
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t got %0h exp %0h", $time, (a), (b)); end end
module rsmb_port_bench
  import rsmb_pkg::*;
;
  localparam int          CK  = 200_000;
  localparam int          MS  = CK / 1000;
  localparam logic [15:0] REV = 16'h0a5c;  // Arbitrary value
  logic         ref_clk = 1'b0, rst = 1'b1, rxd, txd, tx_en, cfg_err, to, en_p = 1'b0;
  logic         buf_wr = 1'b0, tx_start = 1'b0, asc = 1'b0;
  logic [6:0]   buf_addr = 7'h00;
  logic [7:0]   buf_wdata = 8'h00, buf_rdata, tx_len = 8'h00, deriv, turn, rb[$];
  logic [15:0]  fw_rev, qty;
  logic [1:0]   bs[5] = '{SEL_RATE, SEL_TURN, SEL_PROTO, SEL_ADDR, SEL_ADDR};
  logic [7:0]   bd[5] = '{8'h0a, 8'hfb, 8'h03, 8'h00, 8'hf8};
  rsmb_cfg_wr_s cfg_wr = '0;
  rsmb_cfg_s    cfg;
  rsmb_frame_s  frame, fr;
  integer       seed = 32'h2b02;
  int           bad_count = 0, samples_checked = 0, err_n = 0, fr_n = 0, fall_n = 0;
  int           fr_t, en_t, fall_t, end_t, g, to_t = 0;

  rsmb_port #(.CLK_HZ(CK), .FW_REV(REV)) DUT (
    .ref_clk(ref_clk), .rst(rst), .rxd(rxd), .txd(txd), .tx_en(tx_en), .cfg_wr(cfg_wr),
    .cfg(cfg), .cfg_err(cfg_err), .derivative_strap(8'h25), .derivative_code(deriv),
    .firmware_revision(fw_rev), .buf_wr(buf_wr), .buf_addr(buf_addr),
    .buf_wdata(buf_wdata), .buf_rdata(buf_rdata), .tx_start(tx_start), .tx_len(tx_len),
    .frame(frame), .resp_timeout(to)
  );
  rsmb_host #(.CK(CK)) host (.ref_clk(ref_clk), .txd(txd), .tx_en(tx_en), .rxd(rxd));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    en_p <= tx_en;
    if (cfg_err === 1'b1)
      err_n <= err_n + 1;
    if (frame !== '0) begin
      fr   <= frame;
      fr_t <= host.cyc;
      fr_n <= fr_n + 1;
    end
    if (tx_en === 1'b1 && en_p === 1'b0)
      en_t <= host.cyc;
    if (tx_en === 1'b0 && en_p === 1'b1) begin
      fall_t <= host.cyc;
      fall_n <= fall_n + 1;
    end
    if (to === 1'b1)
      to_t <= host.cyc;
    if (host.cyc > 90000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  function automatic int bits(input int code);
    int br[10] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
    return CK / br[code];
  endfunction : bits

  task automatic cw(input logic [1:0] sel, input logic [7:0] d, input logic via, input int bad);
    int e0;
    e0 = err_n;
    @(posedge ref_clk);
    cfg_wr <= '{1'b1, via, sel, d};
    @(posedge ref_clk);
    cfg_wr <= '0;
    tick(3);
    `CHK(err_n - e0, bad)
  endtask : cw

  task automatic req(input logic [7:0] a, input logic [7:0] fc, input logic [15:0] q,
                     input int pad);
    int n0;
    n0 = fr_n;
    host.txq = '{a, fc, 8'h00, 8'h00, q[15:8], q[7:0], 8'h5a, 8'ha5};
    repeat (pad) host.txq.push_back(8'h01);
    @(posedge ref_clk);
    host.send_q();
    end_t = host.cyc;
    for (int i = 0; i < 2000 && fr_n == n0; i++)
      @(posedge ref_clk);
  endtask : req

  task automatic reply(input int n);
    int f0;
    f0 = fall_n;
    host.got.delete();
    rb.delete();
    for (int i = 0; i < n; i++) begin
      rb.push_back(8'($random(seed)));
      buf_wr    <= 1'b1;
      buf_addr  <= 7'(i);
      buf_wdata <= rb[i];
      @(posedge ref_clk);
    end
    buf_wr   <= 1'b0;
    tx_start <= 1'b1;
    tx_len   <= 8'(n);
    @(posedge ref_clk);
    tx_start <= 1'b0;
    for (int i = 0; i < 8000 && fall_n == f0; i++)
      @(posedge ref_clk);
    tick(4);
    g = MS + (turn >= 2 ? turn * MS : 0);
    `CHK(en_t - fr_t >= g && en_t - fr_t <= g + 4, 1'b1)
    `CHK(host.st0 - en_t, turn == 0 ? 0 : MS)
    `CHK((fall_t - host.stl - (asc ? 10 : 11) * host.bitc - MS) inside {[0:3]}, 1'b1)
    `CHK(host.got.size(), n)
    foreach (rb[i])
      `CHK(host.got[i], asc ? {^rb[i][6:0], rb[i][6:0]} : rb[i])
    `CHK(host.stop_bad, 1'b0)
    host.gap(1);
  endtask : reply

  initial begin
    tick(6);
    `CHK(cfg, rsmb_cfg_s'{8'h06, 8'h02, 8'h01, 2'h1})
    rst <= 1'b0;
    tick(2);
    `CHK(deriv, 8'h10)
    `CHK(fw_rev, REV)
    `CHK({tx_en, txd}, 2'b01)
    for (int k = 0; k < 5; k++)
      cw(bs[k], bd[k], 1'b0, 1);
    for (int k = 0; k < 10; k++) begin
      cw(SEL_RATE, 8'(k), 1'b0, 0);
      `CHK(cfg.rate, 8'(k))
    end
    cw(SEL_RATE, 8'h06, 1'b0, 0);
    cw(SEL_PROTO, 8'h00, 1'b0, 0);
    cw(SEL_RATE, 8'h08, 1'b0, 1);
    cw(SEL_PROTO, 8'h01, 1'b0, 0);
    cw(SEL_ADDR, 8'hf7, 1'b0, 0);
    cw(SEL_TURN, 8'hfa, 1'b0, 0);
    `CHK(cfg, rsmb_cfg_s'{8'h06, 8'hfa, 8'hf7, 2'h1})
    cw(SEL_ADDR, 8'h01, 1'b0, 0);
    // Register counts at and past the limit, then random ones
    for (int t = 0; t < 4; t++) begin
      turn = t == 3 ? 8'h05 : 8'(t);
      cw(SEL_TURN, turn, 1'b0, 0);
      qty = t == 0 ? 16'h0010 : t == 1 ? 16'h0011 : 16'(1 + {$random(seed)} % 15);
      req(8'h01, t[0] ? FC_RD_IN : FC_WR_MULTI, qty, 0);
      `CHK(fr.ok, qty inside {[1:16]})
      `CHK(fr.exc, !(qty inside {[1:16]}))
      g = turn * MS > 77 * host.bitc / 2 ? turn * MS : 77 * host.bitc / 2;
      `CHK(fr_t - end_t + host.bitc >= g && fr_t - end_t <= g + 2, 1'b1)
      `CHK(fr.len, 8'h08)
      buf_addr <= 7'h01;
      tick(2);
      `CHK(buf_rdata, t[0] ? FC_RD_IN : FC_WR_MULTI)
      reply(1 + t);
    end
    turn = 8'h00;
    cw(SEL_TURN, turn, 1'b0, 0);
    cw(SEL_PROTO, 8'h02, 1'b0, 0);
    g = fr_n;
    req(8'h01, FC_RD_HOLD, 16'h0001, 0);
    cw(SEL_PROTO, 8'h01, 1'b0, 0);
    req(8'h07, FC_RD_HOLD, 16'h0001, 0);
    `CHK(fr_n, g)
    req(8'h00, FC_WR_MULTI, 16'h0001, 0);
    `CHK({fr.ok, fr.bcast}, 2'b11)
    req(8'h01, FC_RD_IN, 16'h0002, 0);
    for (int i = 0; i < 120 * MS && to_t == 0; i++)
      tick(1);
    `CHK((to_t - fr_t) inside {[100 * MS - 2:100 * MS + 4]}, 1'b1)
    // Rate written over the link must wait for the reply
    req(8'h01, FC_RD_HOLD, 16'h0004, 0);
    cw(SEL_RATE, 8'h07, 1'b1, 0);
    `CHK(cfg.rate, 8'h06)
    reply(2);
    `CHK(cfg.rate, 8'h07)
    host.gap(20);
    host.bitc = bits(7);
    req(8'h01, FC_RD_HOLD, 16'h0001, 0);
    `CHK(fr.ok, 1'b1)
    reply(1);
    // Ascii frame: bit 7 of each byte already carries even parity
    cw(SEL_PROTO, 8'h00, 1'b0, 0);
    asc = 1'b1;
    req(8'h41, 8'h42, 16'h0003, 0);
    `CHK({fr.ok, fr.len}, {1'b1, 8'h08})
    buf_addr <= 7'h07;
    tick(2);
    `CHK(buf_rdata, 8'h25)
    reply(1);
    cw(SEL_PROTO, 8'h01, 1'b0, 0);
    asc = 1'b0;
    req(8'h01, FC_RD_HOLD, 16'h0001, 121);
    `CHK(fr.err, 1'b1)
    wrap_up();
  end
endmodule : rsmb_port_bench
